// *** rtl/load_exchange_block_ops.sv ***
// Executor for the load, stack, exchange, block copy and block search instructions.
//
// Operation
// - Stack store and retrieve adjust stack pointer themselves.
// - Block ops: parity flag clear when counter reaches zero.
// - Block search: zero flag set on accumulator match.
// - Search reads at source pair, counts with count pair.
// - Copy reads at source pair, writes at target pair.
// - Ascending repeat copy steps pointers up until zero.
// - Descending repeat copy steps pointers down until zero.
// - Ascending repeat search stops on zero or match.
// - Load pair field: count, target, source, stack pointer.
// - Stack pair field swaps stack pointer for accumulator-flags.
// - Sixteen-bit memory transfers: low byte at lower address.
// - Eight-bit register field accepts all seven registers.
`timescale 1ns/1ps
`default_nettype none

module load_exchange_block_ops
    import load_exchange_block_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Execution control
    input wire logic run_in,
    output logic instr_done_out,
    output logic [15:0] pc_out,
    // Register state
    output logic [7:0] acc_out,
    output logic [7:0] flags_out,
    output logic [15:0] byte_count_pair_out,
    output logic [15:0] target_pointer_pair_out,
    output logic [15:0] source_pointer_pair_out,
    output logic [15:0] stack_pointer_out,
    // Byte-wide memory, read data valid the cycle after mem_rd_out
    output logic [15:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    input wire logic [7:0] mem_rdata_in
);

    ////////////////////////////////////////////////////////////////////////////
    // Pair selection helpers.

    function automatic logic [2:0] pair_hi_idx(input logic [1:0] sel);
        pair_hi_idx = (sel == PAIR_SEL_LAST) ? IDX_ACC : {sel, 1'b0};
    endfunction : pair_hi_idx

    function automatic logic [2:0] pair_lo_idx(input logic [1:0] sel);
        pair_lo_idx = (sel == PAIR_SEL_LAST) ? IDX_FLAGS : {sel, 1'b1};
    endfunction : pair_lo_idx

    // Code 3 is the stack pointer for loads and accumulator-flags for stack ops.
    function automatic logic [15:0] pair_rd(input gpr_type g, input logic [15:0] sp,
                                            input logic [1:0] sel, input logic stk);
        if (sel == PAIR_SEL_LAST && !stk) begin
            pair_rd = sp;
        end else begin
            pair_rd = {g[pair_hi_idx(sel)], g[pair_lo_idx(sel)]};
        end
    endfunction : pair_rd

    function automatic gpr_type pair_wr(input gpr_type g, input logic [1:0] sel,
                                        input logic [15:0] val);
        pair_wr = g;
        pair_wr[pair_hi_idx(sel)] = val[15:8];
        pair_wr[pair_lo_idx(sel)] = val[7:0];
    endfunction : pair_wr

    ////////////////////////////////////////////////////////////////////////////
    // State.

    state_type st_reg, st_next, ret_reg, ret_next;
    gpr_type gpr_reg, gpr_next;
    logic [15:0] pc_reg, pc_next, op_pc_reg, op_pc_next, sp_reg, sp_next;
    logic [15:0] tmp_reg, tmp_next, addr_reg, addr_next;
    logic [7:0] op_reg, op_next, byte_reg, byte_next, wdata_reg, wdata_next;
    logic pre_reg, pre_next, rd_reg, rd_next, wr_reg, wr_next, done_reg, done_next;

    logic [7:0] rdata;
    logic [15:0] bc, de, hl, bc_dec, nn;
    logic [7:0] diff;
    logic blk_rep, blk_down, blk_search, match, term;
    logic [15:0] st_pair;

    assign rdata = mem_rdata_in;
    assign st_pair = pair_rd(gpr_reg, sp_reg, op_reg[5:4], 1'b0);
    assign bc = {gpr_reg[0], gpr_reg[1]};
    assign de = {gpr_reg[2], gpr_reg[3]};
    assign hl = {gpr_reg[4], gpr_reg[5]};
    assign bc_dec = bc - ONE_16;
    assign nn = {rdata, tmp_reg[7:0]};
    assign diff = gpr_reg[IDX_ACC] - rdata;
    // Both the B0 family and its 80 family alias count as repeating forms.
    assign blk_rep = op_reg[4] | ~op_reg[5];
    assign blk_down = op_reg[3];
    assign blk_search = op_reg[0];
    assign match = (gpr_reg[IDX_ACC] == rdata);
    assign term = (bc_dec == 16'h0000) || (blk_search && match);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.

    always_comb begin
        st_next = st_reg;
        ret_next = ret_reg;
        gpr_next = gpr_reg;
        pc_next = pc_reg;
        op_pc_next = op_pc_reg;
        sp_next = sp_reg;
        tmp_next = tmp_reg;
        op_next = op_reg;
        byte_next = byte_reg;
        pre_next = pre_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rd_next = 1'b0;
        wr_next = 1'b0;
        done_next = 1'b0;
        case (st_reg)
            ST_FETCH: begin
                // Holding here between instructions is where interrupts would be taken.
                if (run_in) begin
                    op_pc_next = pc_reg;
                    addr_next = pc_reg;
                    rd_next = 1'b1;
                    pc_next = pc_reg + ONE_16;
                    pre_next = 1'b0;
                    ret_next = ST_OPCODE;
                    st_next = ST_WAIT;
                end
            end
            ST_WAIT: st_next = ret_reg;
            ST_OPCODE: begin
                op_next = rdata;
                st_next = ST_FETCH;
                if (rdata == OP_PREFIX || (rdata[7:6] == 2'b00 && rdata[2:0] == 3'b110
                        && rdata[5:3] != IDX_MEM_OPERAND) || (rdata[7:6] == 2'b00
                        && rdata[3:0] == 4'h1) || rdata == 8'h2A || rdata == 8'h22) begin
                    addr_next = pc_reg;
                    rd_next = 1'b1;
                    pc_next = pc_reg + ONE_16;
                    pre_next = (rdata == OP_PREFIX);
                    ret_next = (rdata == OP_PREFIX) ? ST_PREFIX : ST_IMM_LO;
                    st_next = ST_WAIT;
                end else if (rdata[7:6] == 2'b01) begin
                    // Slot 6 means a memory operand, which this block does not execute.
                    if (rdata != OP_HALT && rdata[5:3] != IDX_MEM_OPERAND
                            && rdata[2:0] != IDX_MEM_OPERAND) begin
                        gpr_next[rdata[5:3]] = gpr_reg[rdata[2:0]];
                    end
                    done_next = 1'b1;
                end else if (rdata[7:6] == 2'b11 && rdata[3:0] == 4'h5) begin
                    st_next = ST_PUSH_HI;
                end else if (rdata[7:6] == 2'b11 && rdata[3:0] == 4'h1) begin
                    addr_next = sp_reg;
                    rd_next = 1'b1;
                    sp_next = sp_reg + ONE_16;
                    ret_next = ST_POP_LO;
                    st_next = ST_WAIT;
                end else if (rdata == OP_EX_TARGET_SOURCE) begin
                    gpr_next = pair_wr(pair_wr(gpr_reg, 2'h1, hl), 2'h2, de);
                    done_next = 1'b1;
                end else begin
                    done_next = 1'b1;
                end
            end
            ST_PREFIX: begin
                op_next = rdata;
                st_next = ST_FETCH;
                if (rdata[7:6] == 2'b01 && rdata[2:0] == 3'b011) begin
                    addr_next = pc_reg;
                    rd_next = 1'b1;
                    pc_next = pc_reg + ONE_16;
                    ret_next = ST_IMM_LO;
                    st_next = ST_WAIT;
                end else if (rdata[7] && !rdata[6] && rdata[2:1] == 2'b00) begin
                    st_next = ST_BLK_RD;
                end else begin
                    done_next = 1'b1;
                end
            end
            ST_IMM_LO: begin
                tmp_next = {8'h00, rdata};
                if (!pre_reg && op_reg[2:0] == 3'b110) begin
                    gpr_next[op_reg[5:3]] = rdata;
                    done_next = 1'b1;
                    st_next = ST_FETCH;
                end else begin
                    addr_next = pc_reg;
                    rd_next = 1'b1;
                    pc_next = pc_reg + ONE_16;
                    ret_next = ST_IMM_HI;
                    st_next = ST_WAIT;
                end
            end
            ST_IMM_HI: begin
                tmp_next = nn;
                if (!pre_reg && op_reg[3:0] == 4'h1) begin
                    gpr_next = pair_wr(gpr_reg, op_reg[5:4], nn);
                    if (op_reg[5:4] == PAIR_SEL_LAST) begin
                        gpr_next = gpr_reg;
                        sp_next = nn;
                    end
                    done_next = 1'b1;
                    st_next = ST_FETCH;
                end else if (op_reg[3]) begin
                    addr_next = nn;
                    rd_next = 1'b1;
                    ret_next = ST_LD_LO;
                    st_next = ST_WAIT;
                end else begin
                    addr_next = nn;
                    wdata_next = st_pair[7:0];
                    wr_next = 1'b1;
                    st_next = ST_ST_LO;
                end
            end
            ST_LD_LO: begin
                byte_next = rdata;
                addr_next = tmp_reg + ONE_16;
                rd_next = 1'b1;
                ret_next = ST_LD_HI;
                st_next = ST_WAIT;
            end
            ST_LD_HI: begin
                if (op_reg[5:4] == PAIR_SEL_LAST) begin
                    sp_next = {rdata, byte_reg};
                end else begin
                    gpr_next = pair_wr(gpr_reg, op_reg[5:4], {rdata, byte_reg});
                end
                done_next = 1'b1;
                st_next = ST_FETCH;
            end
            ST_ST_LO: begin
                addr_next = addr_reg + ONE_16;
                wdata_next = st_pair[15:8];
                wr_next = 1'b1;
                done_next = 1'b1;
                st_next = ST_FETCH;
            end
            ST_PUSH_HI: begin
                sp_next = sp_reg - ONE_16;
                addr_next = sp_reg - ONE_16;
                wdata_next = gpr_reg[pair_hi_idx(op_reg[5:4])];
                wr_next = 1'b1;
                st_next = ST_PUSH_LO;
            end
            ST_PUSH_LO: begin
                sp_next = sp_reg - ONE_16;
                addr_next = sp_reg - ONE_16;
                wdata_next = gpr_reg[pair_lo_idx(op_reg[5:4])];
                wr_next = 1'b1;
                done_next = 1'b1;
                st_next = ST_FETCH;
            end
            ST_POP_LO: begin
                gpr_next[pair_lo_idx(op_reg[5:4])] = rdata;
                addr_next = sp_reg;
                rd_next = 1'b1;
                sp_next = sp_reg + ONE_16;
                ret_next = ST_POP_HI;
                st_next = ST_WAIT;
            end
            ST_POP_HI: begin
                gpr_next[pair_hi_idx(op_reg[5:4])] = rdata;
                done_next = 1'b1;
                st_next = ST_FETCH;
            end
            ST_BLK_RD: begin
                addr_next = hl;
                rd_next = 1'b1;
                ret_next = ST_BLK_DO;
                st_next = ST_WAIT;
            end
            ST_BLK_DO: begin
                gpr_next = pair_wr(gpr_reg, 2'h0, bc_dec);
                gpr_next = pair_wr(gpr_next, 2'h2, blk_down ? hl - ONE_16 : hl + ONE_16);
                gpr_next[IDX_FLAGS][FLAG_PARITY_OVF] = (bc_dec != 16'h0000);
                gpr_next[IDX_FLAGS][FLAG_HALF] = blk_search
                    && (gpr_reg[IDX_ACC][3:0] < rdata[3:0]);
                gpr_next[IDX_FLAGS][FLAG_SUBTRACT] = blk_search;
                if (blk_search) begin
                    gpr_next[IDX_FLAGS][FLAG_ZERO] = match;
                    gpr_next[IDX_FLAGS][FLAG_SIGN] = diff[7];
                end else begin
                    // Copy: byte read from the source goes to the target pair.
                    gpr_next = pair_wr(gpr_next, 2'h1,
                        blk_down ? de - ONE_16 : de + ONE_16);
                    addr_next = de;
                    wdata_next = rdata;
                    wr_next = 1'b1;
                end
                // Re-running the whole opcode lets a pending interrupt in between steps.
                if (blk_rep && !term) begin
                    pc_next = op_pc_reg;
                end
                done_next = 1'b1;
                st_next = ST_FETCH;
            end
            default: st_next = ST_FETCH;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            st_reg <= ST_FETCH;
            ret_reg <= ST_FETCH;
            gpr_reg <= {8{GPR_RESET}};
            pc_reg <= PC_RESET;
            op_pc_reg <= PC_RESET;
            sp_reg <= SP_RESET;
            tmp_reg <= PC_RESET;
            op_reg <= GPR_RESET;
            byte_reg <= GPR_RESET;
            pre_reg <= 1'b0;
            addr_reg <= PC_RESET;
            wdata_reg <= GPR_RESET;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            ret_reg <= ret_next;
            gpr_reg <= gpr_next;
            pc_reg <= pc_next;
            op_pc_reg <= op_pc_next;
            sp_reg <= sp_next;
            tmp_reg <= tmp_next;
            op_reg <= op_next;
            byte_reg <= byte_next;
            pre_reg <= pre_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            done_reg <= done_next;
        end
    end

    assign instr_done_out = done_reg;
    assign pc_out = pc_reg;
    assign acc_out = gpr_reg[IDX_ACC];
    assign flags_out = gpr_reg[IDX_FLAGS];
    assign byte_count_pair_out = bc;
    assign target_pointer_pair_out = de;
    assign source_pointer_pair_out = hl;
    assign stack_pointer_out = sp_reg;
    assign mem_addr_out = addr_reg;
    assign mem_wdata_out = wdata_reg;
    assign mem_rd_out = rd_reg;
    assign mem_wr_out = wr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    push_sp_pre_a: assert property ((st_reg == ST_PUSH_HI) |=>
        (mem_wr_out && mem_addr_out == sp_reg && sp_reg == $past(sp_reg) - ONE_16))
        else $error("push did not predecrement the stack pointer");
    pop_sp_post_a: assert property ((st_reg == ST_POP_LO) |=>
        (sp_reg == $past(sp_reg) + ONE_16) ##1 (st_reg == ST_POP_HI))
        else $error("pop did not postincrement the stack pointer");
    block_parity_a: assert property ((st_reg == ST_BLK_DO) |=>
        (flags_out[FLAG_PARITY_OVF] == (byte_count_pair_out != 16'h0000)))
        else $error("block parity flag does not track the counter");
    search_zero_a: assert property ((st_reg == ST_BLK_DO && blk_search) |=>
        (flags_out[FLAG_ZERO] == ($past(acc_out) == $past(mem_rdata_in))))
        else $error("search zero flag wrong");
    block_read_a: assert property ((st_reg == ST_BLK_RD) |=>
        (mem_rd_out && mem_addr_out == source_pointer_pair_out))
        else $error("block read not at source pointer");
    copy_write_a: assert property ((st_reg == ST_BLK_DO && !blk_search) |=>
        (mem_wr_out && mem_addr_out == $past(de) && mem_wdata_out == $past(mem_rdata_in)))
        else $error("copy write not at target pointer");
    copy_up_step_a: assert property ((st_reg == ST_BLK_DO && !blk_search && !blk_down)
        |=> (source_pointer_pair_out == $past(hl) + ONE_16
        && target_pointer_pair_out == $past(de) + ONE_16
        && byte_count_pair_out == $past(bc) - ONE_16))
        else $error("ascending copy step wrong");
    copy_down_step_a: assert property ((st_reg == ST_BLK_DO && !blk_search && blk_down)
        |=> (source_pointer_pair_out == $past(hl) - ONE_16
        && target_pointer_pair_out == $past(de) - ONE_16))
        else $error("descending copy step wrong");
    search_up_step_a: assert property ((st_reg == ST_BLK_DO && blk_search && !blk_down)
        |=> (source_pointer_pair_out == $past(hl) + ONE_16))
        else $error("ascending search step wrong");
    repeat_restart_a: assert property ((st_reg == ST_BLK_DO && blk_rep && !term)
        |=> (pc_out == $past(op_pc_reg) && instr_done_out))
        else $error("unfinished repeat did not restart its opcode");
    store_order_a: assert property ((st_reg == ST_ST_LO) |=>
        (mem_wr_out && mem_addr_out == $past(mem_addr_out) + ONE_16))
        else $error("high byte not at next address");

    repeat_copy_c: cover property ((st_reg == ST_BLK_DO && !blk_search && blk_rep && !term));
    search_hit_c: cover property ((st_reg == ST_BLK_DO && blk_search && match));
    push_pop_c: cover property ((st_reg == ST_PUSH_LO) ##[1:40] (st_reg == ST_POP_HI));

endmodule : load_exchange_block_ops

`default_nettype wire

// *** rtl/load_exchange_block_pkg.sv ***
// Package with encodings, register indices and reset values for the load and block executor.
package load_exchange_block_pkg;

    // Eight-bit register file indices; slot 6 holds the flags next to the accumulator.
    localparam logic [2:0] IDX_B = 3'h0;
    localparam logic [2:0] IDX_C = 3'h1;
    localparam logic [2:0] IDX_FLAGS = 3'h6;
    localparam logic [2:0] IDX_ACC = 3'h7;
    localparam logic [2:0] IDX_MEM_OPERAND = 3'h6;

    // Pair select code that changes meaning between load and stack forms.
    localparam logic [1:0] PAIR_SEL_LAST = 2'h3;

    // Flag bit positions.
    localparam int FLAG_SIGN = 7;
    localparam int FLAG_ZERO = 6;
    localparam int FLAG_HALF = 4;
    localparam int FLAG_PARITY_OVF = 2;
    localparam int FLAG_SUBTRACT = 1;

    // Opcodes handled outside the bit-field decode.
    localparam logic [7:0] OP_PREFIX = 8'hED;
    localparam logic [7:0] OP_HALT = 8'h76;
    localparam logic [7:0] OP_EX_TARGET_SOURCE = 8'hEB;

    // Repeated block forms after the prefix.
    localparam logic [7:0] BLOCK_COPY_UP_REPEAT = 8'hB0;
    localparam logic [7:0] BLOCK_COPY_DOWN_REPEAT = 8'hB8;
    localparam logic [7:0] BLOCK_SEARCH_UP_REPEAT = 8'hB1;
    localparam logic [7:0] BLOCK_SEARCH_DOWN_REPEAT = 8'hB9;

    // Values after reset.
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'hFFFF;
    localparam logic [7:0] GPR_RESET = 8'h00;
    localparam logic [15:0] ONE_16 = 16'h0001;

    typedef logic [7:0][7:0] gpr_type;

    typedef enum logic [3:0] {
        ST_FETCH, ST_WAIT, ST_OPCODE, ST_PREFIX, ST_IMM_LO, ST_IMM_HI,
        ST_LD_LO, ST_LD_HI, ST_ST_LO, ST_PUSH_HI, ST_PUSH_LO,
        ST_POP_LO, ST_POP_HI, ST_BLK_RD, ST_BLK_DO
    } state_type;

endpackage : load_exchange_block_pkg

// *** verification/byte_memory_model.sv ***
// Behavioural byte-wide program and data memory facing the executor.
`timescale 1ns/1ps
`default_nettype none

module byte_memory_model (
    // Clock
    input wire logic core_clk_in,
    // Memory bus from the executor
    input wire logic [15:0] mem_addr_in,
    input wire logic [7:0] mem_wdata_in,
    input wire logic mem_rd_in,
    input wire logic mem_wr_in,
    output logic [7:0] mem_rdata_out
);
    logic [7:0] mem [0:65535];

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h00;
        end
        mem_rdata_out = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data is valid for one cycle only; afterwards the bus toggles to its inverse every cycle,
    // so a sample one cycle late can never pass by luck.
    always @(posedge core_clk_in) begin
        if (mem_wr_in) begin
            mem[mem_addr_in] <= mem_wdata_in;
        end
        if (mem_rd_in) begin
            mem_rdata_out <= mem[mem_addr_in];
        end else begin
            mem_rdata_out <= ~mem_rdata_out;
        end
    end
endmodule : byte_memory_model
`default_nettype wire

// *** verification/load_exchange_block_ops_test.sv ***
// Self-checking testbench for the load, stack and block executor.
`timescale 1ns/1ps
`default_nettype none

module load_exchange_block_ops_test;
    import load_exchange_block_pkg::*;
    logic core_clk_in, srst_in, run_in, instr_done_out, mem_rd_out, mem_wr_out;
    logic [7:0] acc_out, flags_out, mem_wdata_out, mem_rdata_in, a_v, c_v, d0, d1;
    logic [15:0] pc_out, byte_count_pair_out, target_pointer_pair_out;
    logic [15:0] source_pointer_pair_out, stack_pointer_out, mem_addr_out, pc_w, sp_e, hl_e;
    int n_mismatch, check_count, cycles;

    load_exchange_block_ops load_exchange_block_ops_inst (.core_clk_in(core_clk_in),
        .srst_in(srst_in), .run_in(run_in), .instr_done_out(instr_done_out), .pc_out(pc_out),
        .acc_out(acc_out), .flags_out(flags_out), .byte_count_pair_out(byte_count_pair_out),
        .target_pointer_pair_out(target_pointer_pair_out),
        .source_pointer_pair_out(source_pointer_pair_out),
        .stack_pointer_out(stack_pointer_out), .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
        .mem_rdata_in(mem_rdata_in));
    byte_memory_model byte_memory_model_inst (.core_clk_in(core_clk_in),
        .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .mem_rd_in(mem_rd_out),
        .mem_wr_in(mem_wr_out), .mem_rdata_out(mem_rdata_in));

    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // The whole program needs a few hundred cycles; this ceiling cuts a hang short.
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [15:0] mem16(input logic [15:0] a);
        return {8'h00, byte_memory_model_inst.mem[a]};
    endfunction : mem16

    function automatic logic [15:0] pair_of(input logic [1:0] s);
        case (s)
            2'h0: return byte_count_pair_out;
            2'h1: return target_pointer_pair_out;
            2'h2: return source_pointer_pair_out;
            default: return stack_pointer_out;
        endcase
    endfunction : pair_of

    // Program bytes are placed ahead of the fetch, which runs freely with run_in high.
    task automatic emit(input logic [7:0] b);
        byte_memory_model_inst.mem[pc_w] = b;
        pc_w++;
    endtask : emit

    // Results are sampled mid-cycle while the completion pulse stands.
    task automatic step(input int n);
        repeat (n) begin
            do @(negedge core_clk_in); while (instr_done_out !== 1'b1);
        end
    endtask : step

    task automatic ld_pair(input logic [1:0] sel, input logic [15:0] v);
        emit({2'b00, sel, 4'h1});
        emit(v[7:0]);
        emit(v[15:8]);
        step(1);
        check("load pair", pair_of(sel), v);
    endtask : ld_pair

    task automatic block(input logic [7:0] op, input int iters);
        logic [15:0] at;
        at = pc_w;
        emit(OP_PREFIX);
        emit(op);
        for (int i = 0; i < iters; i++) begin
            step(1);
            if (i < iters - 1) begin
                check("repeat pc", pc_out, at);
                check("pv busy", {15'h0000, flags_out[FLAG_PARITY_OVF]}, 16'h0001);
            end
        end
        check("pc after block", pc_out, at + 16'h0002);
        // The last copy write lands one edge after the completion pulse.
        @(negedge core_clk_in);
    endtask : block

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        srst_in = 1'b1;
        run_in = 1'b0;
        n_mismatch = 0;
        check_count = 0;
        cycles = 0;
        pc_w = 16'h0000;
        a_v = 8'($urandom(32'h40a6));
        repeat (3) @(posedge core_clk_in);
        srst_in <= 1'b0;
        @(negedge core_clk_in);
        check("sp reset", stack_pointer_out, SP_RESET);
        check("pc reset", pc_out, PC_RESET);
        c_v = 8'($urandom());
        sp_e = {4'h8, 12'($urandom() | 32'h4)};
        hl_e = 16'($urandom());
        @(posedge core_clk_in);
        run_in <= 1'b1;
        ld_pair(2'h0, 16'($urandom()));
        ld_pair(2'h1, 16'($urandom()));
        ld_pair(2'h2, hl_e);
        ld_pair(2'h3, sp_e);
        emit(8'h3E);
        emit(a_v);
        emit(8'h47);
        emit(8'h0E);
        emit(c_v);
        step(3);
        check("reg loads", byte_count_pair_out, {a_v, c_v});
        emit(8'hC5);
        step(1);
        // The low byte is written one edge after the completion pulse.
        @(negedge core_clk_in);
        check("push sp", stack_pointer_out, sp_e - 16'h0002);
        check("push hi", mem16(sp_e - 16'h0001), {8'h00, a_v});
        check("push lo", mem16(sp_e - 16'h0002), {8'h00, c_v});
        emit(8'hF5);
        emit(8'hD1);
        step(2);
        check("pop af", target_pointer_pair_out, {a_v, flags_out});
        check("pop sp", stack_pointer_out, sp_e - 16'h0002);
        emit(8'h22);
        emit(8'h00);
        emit(8'h30);
        step(1);
        @(negedge core_clk_in);
        check("store lo", mem16(16'h3000), {8'h00, hl_e[7:0]});
        check("store hi", mem16(16'h3001), {8'h00, hl_e[15:8]});
        emit(OP_PREFIX);
        emit(8'h4B);
        emit(8'h00);
        emit(8'h30);
        step(1);
        check("load pair mem", byte_count_pair_out, hl_e);
        d0 = {1'b0, 7'($urandom())};
        d1 = d0 ^ 8'h80;
        byte_memory_model_inst.mem[16'h4000] = d0;
        byte_memory_model_inst.mem[16'h4001] = d1;
        byte_memory_model_inst.mem[16'h4002] = ~d0;
        ld_pair(2'h2, 16'h4000);
        ld_pair(2'h1, 16'h5000);
        ld_pair(2'h0, 16'h0003);
        block(8'h80, 3);
        check("copy up", mem16(16'h5002), {8'h00, ~d0});
        check("copy up src", source_pointer_pair_out, 16'h4003);
        check("copy up dst", target_pointer_pair_out, 16'h5003);
        check("pv done", {15'h0000, flags_out[FLAG_PARITY_OVF]}, 16'h0000);
        ld_pair(2'h2, 16'h4001);
        ld_pair(2'h1, 16'h6001);
        ld_pair(2'h0, 16'h0002);
        block(8'h88, 2);
        check("copy down", mem16(16'h6000), {8'h00, d0});
        check("copy down src", source_pointer_pair_out, 16'h3FFF);
        check("copy down cnt", byte_count_pair_out, 16'h0000);
        ld_pair(2'h2, 16'h4000);
        ld_pair(2'h0, 16'h0003);
        emit(8'h3E);
        emit(d1);
        step(1);
        block(8'h81, 2);
        check("search z", {15'h0000, flags_out[FLAG_ZERO]}, 16'h0001);
        check("search src", source_pointer_pair_out, 16'h4002);
        check("search cnt", byte_count_pair_out, 16'h0001);
        check("search pv", {15'h0000, flags_out[FLAG_PARITY_OVF]}, 16'h0001);
        final_report();
    end
endmodule : load_exchange_block_ops_test
`default_nettype wire
